// ---- verilog/vfu_unpacker.sv ----
// Operation
// - format 4 bytes Cb,Y,Cr,Y on low lines
// - format 4 may carry embedded sync codes
// - code first byte sits in Cb slot
// - sender sends ones, zero, zero, status
// - status bit 6 is field indicator
// - status bit 5 is vertical blanking
// - status bit 4 marks end/start active video
// - status bit 7 and 3..0 ignored
// - ganged ports carry identical sync and clock
// - 24-bit: one word per clock, falling default
// - both port format codes equal for 5..9
// - codes 5..9 select the five 24-bit maps
// - 16-bit YCrCb alternates Cb then Cr
// - idle words carry blanking levels
// - format 5 red, green, blue lane map
// - format 6 luma and alternating chroma map
// - format 7 luma, Cr, Cb lane map
// - first word after hsync lead is Cb
// - edge select: rising, falling or both
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module vfu_unpacker
  import vfu_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [3:0] i_port_one_format_code,
  input  wire logic [3:0] i_port_two_format_code,
  input  wire logic [1:0] i_latch_edge_select,
  vfu_link_if.dev         link,
  output logic            o_pix_valid,
  output logic [7:0]      o_comp_a,
  output logic [7:0]      o_comp_b,
  output logic [7:0]      o_comp_c,
  output logic            o_pix_ycc,
  output logic            o_field,
  output logic            o_vblank,
  output logic            o_eav,
  output logic            o_sav,
  output logic            o_format_mismatch
);

  typedef enum logic [2:0] {ST_CB, ST_Y0, ST_CR, ST_Y1, ST_Z2, ST_ST} vfu_ph_t;

  typedef struct packed {
    logic [2:0]  clk_s;
    logic [2:0]  hs_s;
    logic [1:0]  de_s;
    logic [11:0] d1_m;
    logic [11:0] d1_s;
    logic [11:0] d2_m;
    logic [11:0] d2_s;
    vfu_ph_t     ph;
    logic [7:0]  prev;
    logic [7:0]  cb;
    logic [7:0]  y0;
    logic [7:0]  cr;
    logic        half;
    logic [11:0] h1;
    logic [11:0] h2;
    logic        pend_v;
    logic [7:0]  pend_a;
    logic [7:0]  pend_b;
    logic [7:0]  pend_c;
    logic        pv;
    logic [7:0]  pa;
    logic [7:0]  pb;
    logic [7:0]  pc;
    logic        ycc;
    logic        field;
    logic        vblank;
    logic        eav;
    logic        sav;
    logic        mism;
  } vfu_dev_st_t;

  vfu_dev_st_t r;
  vfu_dev_st_t n;

  logic        rise;
  logic        fall;
  logic        mux;
  logic        cap;
  logic        hs_lead;
  logic        de;
  logic [7:0]  byte_in;
  logic [7:0]  mid;
  vfu_ph_t     cur_ph;

  // place one pixel on the output registers
  function automatic vfu_dev_st_t emit(input vfu_dev_st_t s, input logic [7:0] a,
                                       input logic [7:0] b, input logic [7:0] c,
                                       input logic y);
    s.pv  = 1'b1;
    s.pa  = a;
    s.pb  = b;
    s.pc  = c;
    s.ycc = y;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge finding on synchronised link clock; stage 0 feeds only stage 1
  assign rise    = r.clk_s[1] & ~r.clk_s[2];
  assign fall    = ~r.clk_s[1] & r.clk_s[2];
  assign hs_lead = r.hs_s[1] & ~r.hs_s[2];
  assign de      = r.de_s[1];
  assign mux     = (i_port_one_format_code == FMT_YCC_MUX);
  // 24-bit formats take one edge only, so both-edge falls back to falling
  assign cap     = (mux && i_latch_edge_select == LES_BOTH) ? (rise | fall) :
                   (i_latch_edge_select == LES_RISE) ? rise : fall;
  assign byte_in = r.d1_s[7:0];
  assign mid     = mid_lines(r.d1_s, r.d2_s);
  assign cur_ph  = hs_lead ? ST_CB : r.ph;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n       = r;
    n.pv    = 1'b0;
    n.eav   = 1'b0;
    n.sav   = 1'b0;
    n.clk_s = {r.clk_s[1:0], link.port_one_pixel_clock};
    n.hs_s  = {r.hs_s[1:0], link.port_one_hsync};
    n.de_s  = {r.de_s[0], link.port_one_data_valid};
    n.d1_m  = link.port_one_data;
    n.d1_s  = r.d1_m;
    n.d2_m  = link.port_two_data;
    n.d2_s  = r.d2_m;
    // ganged formats need both selectors alike; flagged, not enforced
    n.mism  = (i_port_one_format_code >= FMT_RGB_TV) &&
              (i_port_one_format_code <= FMT_RGB_NG) &&
              (i_port_one_format_code != i_port_two_format_code);

    // second pixel of a pair leaves one cycle after the first
    if (r.pend_v) begin
      n        = emit(n, r.pend_a, r.pend_b, r.pend_c, r.ycc);
      n.pend_v = 1'b0;
    end

    if (mux) begin
      n.ph = cur_ph;
      if (cap) begin
        n.prev = byte_in;
        // code bytes only steer the phase, so a misaligned code leaks no sample
        if (r.prev == TRC_ONES && byte_in == TRC_ZERO && cur_ph != ST_ST) begin
          n.ph = ST_Z2;
        end else if (byte_in == TRC_ONES && cur_ph != ST_ST) begin
          n.ph = cur_ph;
        end else begin
          unique case (cur_ph)
            ST_CB: begin
              n.cb = byte_in;
              n.ph = ST_Y0;
            end
            ST_Y0: begin
              n.y0 = byte_in;
              n.ph = ST_CR;
            end
            ST_CR: begin
              n.cr = byte_in;
              n    = emit(n, r.y0, r.cb, byte_in, 1'b1);
              n.ph = ST_Y1;
            end
            ST_Y1: begin
              n    = emit(n, byte_in, r.cb, r.cr, 1'b1);
              n.ph = ST_CB;
            end
            ST_Z2: begin
              // a broken preamble drops back to the chroma slot
              n.ph = (byte_in == TRC_ZERO) ? ST_ST : ST_CB;
            end
            ST_ST: begin
              // status byte: only field, blanking and eav/sav are used
              n.field  = byte_in[SB_FIELD];
              n.vblank = byte_in[SB_VBLANK];
              n.eav    = byte_in[SB_EAV];
              n.sav    = ~byte_in[SB_EAV];
              n.ph     = ST_CB;
            end
          endcase
        end
      end
    end else if (cap && de) begin
      unique case (i_port_one_format_code)
        FMT_RGB_TV, FMT_RGB_NG: begin
          n = emit(n, r.d1_s[11:4], mid, r.d2_s[7:0], 1'b0);
        end
        FMT_YCC24: begin
          n = emit(n, r.d1_s[11:4], r.d2_s[7:0], mid, 1'b1);
        end
        FMT_YCC16: begin
          if (!r.half) begin
            n.cb   = mid;
            n.y0   = r.d1_s[11:4];
            n.half = 1'b1;
          end else begin
            n        = emit(n, r.y0, r.cb, mid, 1'b1);
            n.pend_v = 1'b1;
            n.pend_a = r.d1_s[11:4];
            n.pend_b = r.cb;
            n.pend_c = mid;
            n.half   = 1'b0;
          end
        end
        FMT_RGB_OE: begin
          // odd/even pair: first word holds green low and blue of both
          if (!r.half) begin
            n.h1   = r.d1_s;
            n.h2   = r.d2_s;
            n.half = 1'b1;
          end else begin
            n        = emit(n, r.d1_s[11:4], {r.d1_s[3:0], r.h1[11:8]},
                            r.h1[7:0], 1'b0);
            n.pend_v = 1'b1;
            n.pend_a = r.d2_s[11:4];
            n.pend_b = {r.d2_s[3:0], r.h2[11:8]};
            n.pend_c = r.h2[7:0];
            n.half   = 1'b0;
          end
        end
        default: begin
          // multiplexed rgb codes are not unpacked here
          n.half = 1'b0;
        end
      endcase
    end
    // word pairing restarts with every active run
    if (!de) begin
      n.half = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign o_pix_valid       = r.pv;
  assign o_comp_a          = r.pa;
  assign o_comp_b          = r.pb;
  assign o_comp_c          = r.pc;
  assign o_pix_ycc         = r.ycc;
  assign o_field           = r.field;
  assign o_vblank          = r.vblank;
  assign o_eav             = r.eav;
  assign o_sav             = r.sav;
  assign o_format_mismatch = r.mism;

endmodule

// ---- common/vfu_pkg.sv ----
package vfu_pkg;
  // input format codes
  localparam logic [3:0] FMT_YCC_MUX = 4'h4;
  localparam logic [3:0] FMT_RGB_TV  = 4'h5;
  localparam logic [3:0] FMT_YCC16   = 4'h6;
  localparam logic [3:0] FMT_YCC24   = 4'h7;
  localparam logic [3:0] FMT_RGB_OE  = 4'h8;
  localparam logic [3:0] FMT_RGB_NG  = 4'h9;
  // latch edge select codes
  localparam logic [1:0] LES_FALL = 2'h0;
  localparam logic [1:0] LES_RISE = 2'h1;
  localparam logic [1:0] LES_BOTH = 2'h2;
  // timing reference code bytes and status bit positions
  localparam logic [7:0] TRC_ONES  = 8'hff;
  localparam logic [7:0] TRC_ZERO  = 8'h00;
  localparam int         SB_FIELD  = 6;
  localparam int         SB_VBLANK = 5;
  localparam int         SB_EAV    = 4;
  // blanking levels
  localparam logic [7:0] BLANK_Y   = 8'h10;
  localparam logic [7:0] BLANK_C   = 8'h80;
  localparam logic [23:0] BLANK_W16 = 24'h10_8000;
  localparam logic [23:0] BLANK_W24 = 24'h10_8080;
  // source register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_SYNC = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  localparam int CTRL_FMT1_LSB = 0;
  localparam int CTRL_FMT2_LSB = 4;
  localparam int CTRL_EDGE_LSB = 8;
  localparam int CTRL_RUN      = 10;
  localparam int CTRL_DE       = 11;
  localparam int CTRL_HS       = 12;
  localparam int CTRL_VS       = 13;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  // link clock timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // green or chroma split across the two ports
  function automatic logic [7:0] mid_lines(input logic [11:0] d1, input logic [11:0] d2);
    return {d1[3:0], d2[11:8]};
  endfunction

  function automatic logic is_ycc(input logic [3:0] fmt);
    return (fmt == FMT_YCC_MUX) || (fmt == FMT_YCC16) || (fmt == FMT_YCC24);
  endfunction
endpackage

// ---- common/vfu_link_if.sv ----
`timescale 1ns/10ps
interface vfu_link_if;
  logic [11:0] port_one_data;
  logic [11:0] port_two_data;
  logic        port_one_hsync;
  logic        port_one_vsync;
  logic        port_one_data_valid;
  logic        port_one_pixel_clock;
  logic        port_two_hsync;
  logic        port_two_vsync;
  logic        port_two_data_valid;
  logic        port_two_pixel_clock;

  modport ctl (
    output port_one_data, port_two_data, port_one_hsync, port_one_vsync,
    output port_one_data_valid, port_one_pixel_clock, port_two_hsync,
    output port_two_vsync, port_two_data_valid, port_two_pixel_clock
  );
  modport dev (
    input port_one_data, port_two_data, port_one_hsync,
    input port_one_data_valid, port_one_pixel_clock
  );
endinterface

// ---- verilog/vfu_source.sv ----
`timescale 1ns/10ps
module vfu_source
  import vfu_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  vfu_link_if.ctl          link
);

  typedef struct packed {
    logic [13:0] ctrl;
    logic        word_v;
    logic [23:0] word;
    logic        sync_v;
    logic [7:0]  sync_b;
    logic        sync_act;
    logic [1:0]  sidx;
    logic [1:0]  bph;
    logic [7:0]  cnt;
    logic        pclk;
    logic [11:0] d1;
    logic [11:0] d2;
    logic        rd_ack;
    logic [31:0] rdata;
  } vfu_src_st_t;

  vfu_src_st_t r;
  vfu_src_st_t n;

  logic [3:0]  fmt;
  logic [1:0]  les;
  logic        run;
  logic        wr_ok;
  logic        busy;
  logic        upd;
  logic [31:0] rd_mux;
  logic [7:0]  tx_byte;

  assign fmt  = r.ctrl[CTRL_FMT1_LSB +: 4];
  assign les  = r.ctrl[CTRL_EDGE_LSB +: 2];
  assign run  = r.ctrl[CTRL_RUN];
  // a full holding register stalls the bus instead of dropping data
  assign busy = i_avs_write && ((i_avs_address == REG_DATA && r.word_v) ||
                                (i_avs_address == REG_SYNC && r.sync_v));
  assign o_avs_waitrequest = busy | (i_avs_read & ~r.rd_ack);
  assign wr_ok = i_avs_write & ~busy;
  assign o_avs_readdata = r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // update points sit half an edge away from the receiver's capture edge
  always_comb begin
    if (!run) begin
      upd = 1'b0;
    end else if (fmt == FMT_YCC_MUX && les == LES_BOTH) begin
      upd = (r.cnt == 8'(HALF_CYC / 2)) || (r.cnt == 8'(HALF_CYC + HALF_CYC / 2));
    end else if (les == LES_RISE) begin
      upd = (r.cnt == 8'(HALF_CYC));
    end else begin
      upd = (r.cnt == 8'h00);
    end
  end

  always_comb begin
    unique case (i_avs_address)
      REG_CTRL: rd_mux = {18'h0_0000, r.ctrl};
      REG_DATA: rd_mux = {8'h00, r.word};
      REG_SYNC: rd_mux = {24'h00_0000, r.sync_b};
      REG_STAT: rd_mux = {30'h0000_0000, r.sync_v, r.word_v};
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // byte for the next multiplexed slot
  always_comb begin
    if (r.sync_act) begin
      tx_byte = (r.sidx == 2'h3) ? r.sync_b : TRC_ZERO;
    end else if (r.sync_v && r.bph == 2'h0) begin
      tx_byte = TRC_ONES;
    end else if (r.word_v) begin
      tx_byte = r.word[7:0];
    end else begin
      tx_byte = r.bph[0] ? BLANK_Y : BLANK_C;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n        = r;
    n.rd_ack = i_avs_read & ~r.rd_ack;
    if (i_avs_read && !r.rd_ack) begin
      n.rdata = rd_mux;
    end
    if (wr_ok && i_avs_address == REG_CTRL) begin
      n.ctrl = i_avs_writedata[13:0];
      // hsync lead restarts the byte phase, as the receiver does
      if (i_avs_writedata[CTRL_HS] && !r.ctrl[CTRL_HS]) begin
        n.bph = 2'h0;
      end
    end
    if (wr_ok && i_avs_address == REG_DATA) begin
      n.word   = i_avs_writedata[23:0];
      n.word_v = 1'b1;
    end
    if (wr_ok && i_avs_address == REG_SYNC) begin
      n.sync_b = i_avs_writedata[7:0];
      n.sync_v = 1'b1;
    end

    // link clock divider; clock parks low while stopped
    if (!run) begin
      n.cnt  = 8'h00;
      n.pclk = 1'b0;
    end else begin
      n.cnt  = (r.cnt == 8'(2 * HALF_CYC - 1)) ? 8'h00 : r.cnt + 8'h01;
      n.pclk = (r.cnt < 8'(HALF_CYC));
    end

    if (upd) begin
      if (fmt == FMT_YCC_MUX) begin
        n.d1  = {4'h0, tx_byte};
        n.d2  = 12'h000;
        n.bph = r.bph + 2'h1;
        if (r.sync_act) begin
          n.sidx = r.sidx + 2'h1;
          if (r.sidx == 2'h3) begin
            n.sync_act = 1'b0;
            n.sync_v   = 1'b0;
          end
        end else if (r.sync_v && r.bph == 2'h0) begin
          n.sync_act = 1'b1;
          n.sidx     = 2'h1;
        end else if (r.word_v) begin
          n.word_v = 1'b0;
        end
      end else if (r.word_v) begin
        n.d1     = r.word[23:12];
        n.d2     = r.word[11:0];
        n.word_v = 1'b0;
      end else begin
        // idle words carry blanking levels for the format
        n.d1 = (fmt == FMT_YCC16) ? BLANK_W16[23:12] :
               (fmt == FMT_YCC24) ? BLANK_W24[23:12] : 12'h000;
        n.d2 = (fmt == FMT_YCC16) ? BLANK_W16[11:0] :
               (fmt == FMT_YCC24) ? BLANK_W24[11:0] : 12'h000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r      <= '0;
      r.ctrl <= CTRL_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // both ports carry the same timing and clock
  assign link.port_one_data        = r.d1;
  assign link.port_two_data        = r.d2;
  assign link.port_one_hsync       = r.ctrl[CTRL_HS];
  assign link.port_two_hsync       = r.ctrl[CTRL_HS];
  assign link.port_one_vsync       = r.ctrl[CTRL_VS];
  assign link.port_two_vsync       = r.ctrl[CTRL_VS];
  assign link.port_one_data_valid  = r.ctrl[CTRL_DE];
  assign link.port_two_data_valid  = r.ctrl[CTRL_DE];
  assign link.port_one_pixel_clock = r.pclk;
  assign link.port_two_pixel_clock = r.pclk;

endmodule

// ---- verif/vfu_checker.sv ----
`timescale 1ns/10ps
module vfu_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic port_one_hsync,
  input wire logic port_two_hsync,
  input wire logic port_one_vsync,
  input wire logic port_two_vsync,
  input wire logic port_one_data_valid,
  input wire logic port_two_data_valid,
  input wire logic port_one_pixel_clock,
  input wire logic port_two_pixel_clock,
  input wire logic o_pix_valid,
  input wire logic o_eav,
  input wire logic o_sav
);
  default clocking ck @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////
  // low phase of the divided link clock; the high phase may be cut by a stop
  sequence clk_low_s;
    !port_one_pixel_clock [*4];
  endsequence
  // a code takes four byte slots, so markers never come close together
  sequence code_gap_s;
    !(o_eav || o_sav) [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  hsync_pair_a: assert property (port_one_hsync == port_two_hsync)
    else $error("hsync differs between ports");
  vsync_pair_a: assert property (port_one_vsync == port_two_vsync)
    else $error("vsync differs between ports");
  valid_pair_a: assert property (port_one_data_valid == port_two_data_valid)
    else $error("data valid differs between ports");
  clock_pair_a: assert property (port_one_pixel_clock == port_two_pixel_clock)
    else $error("pixel clock differs between ports");
  clk_low_a: assert property ($fell(port_one_pixel_clock) |-> clk_low_s)
    else $error("link clock low phase too short");
  code_pulse_a: assert property ((o_eav || o_sav) |=> code_gap_s)
    else $error("sync marker pulses too close");
  eav_sav_excl_a: assert property (!(o_eav && o_sav))
    else $error("end and start markers together");
  code_no_pix_a: assert property ((o_eav || o_sav) |-> !o_pix_valid)
    else $error("pixel issued with a sync marker");
  pix_burst_a: assert property (o_pix_valid [*2] |=> !o_pix_valid)
    else $error("more than two pixels in a row");
endmodule

// ---- verif/vfu_unpacker_tb.sv ----
`timescale 1ns/10ps
module vfu_unpacker_tb;
  import vfu_pkg::*;
  logic        i_clk, i_rst_n, rd, wr, wait_rq, pv, ycc, fld, vbl, eav, sav, mism;
  logic [3:0]  adr, fmt1, fmt2;
  logic [1:0]  les;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  ca, cb, cc, cbm, crm, y0m;
  logic [23:0] w0;
  logic [24:0] pq[$];
  logic [3:0]  eq[$];
  logic        pc_q = 0, hs_q = 0, hs_f = 0, pair = 0;
  int          ph = 0, cn = 0, err_count = 0, checks = 0;

  vfu_link_if link ();
  vfu_source #(.HALF_CYC(4)) vfu_source_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq), .link(link));
  vfu_unpacker vfu_unpacker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_port_one_format_code(fmt1), .i_port_two_format_code(fmt2), .i_latch_edge_select(les),
    .link(link), .o_pix_valid(pv), .o_comp_a(ca), .o_comp_b(cb), .o_comp_c(cc),
    .o_pix_ycc(ycc), .o_field(fld), .o_vblank(vbl), .o_eav(eav), .o_sav(sav),
    .o_format_mismatch(mism));
  vfu_checker vfu_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .port_one_hsync(link.port_one_hsync), .port_two_hsync(link.port_two_hsync),
    .port_one_vsync(link.port_one_vsync), .port_two_vsync(link.port_two_vsync),
    .port_one_data_valid(link.port_one_data_valid),
    .port_two_data_valid(link.port_two_data_valid),
    .port_one_pixel_clock(link.port_one_pixel_clock),
    .port_two_pixel_clock(link.port_two_pixel_clock),
    .o_pix_valid(pv), .o_eav(eav), .o_sav(sav));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    adr <= a; wr <= w; rd <= !w; wdat <= d;
    n = 0;
    do begin @(posedge i_clk); n++; end while (wait_rq !== 1'b0 && n < 300);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
    if (n >= 300) begin chk("bus_timeout", 0, 1); end_sim(); end
  endtask
  // stop the link first so that mode changes never land on a capture edge
  task automatic start(input logic [3:0] f1, f2, input logic [1:0] e, input logic de);
    logic [31:0] w;
    int          n;
    // drain queued words and codes; a half-sent code must not span a restart
    n = 0;
    do begin
      bus(1'b0, REG_STAT, 32'h0000_0000);
      n++;
    end while (q[1:0] !== 2'h0 && n < 300);
    if (n >= 300) begin chk("drain_timeout", 0, 1); end_sim(); end
    bus(1'b1, REG_CTRL, 32'h0000_0000);
    repeat (40) @(posedge i_clk);
    chk("pix_left", 0, 32'(pq.size() + eq.size()));
    pq.delete(); eq.delete(); ph = 0; cn = 0; pair = 0;
    fmt1 <= f1; fmt2 <= f2; les <= e;
    w = 32'(f1) | 32'(f2) << CTRL_FMT2_LSB | 32'(e) << CTRL_EDGE_LSB | 32'(de) << CTRL_DE;
    bus(1'b1, REG_CTRL, w | 32'h1 << CTRL_HS);
    bus(1'b1, REG_CTRL, w | 32'h1 << CTRL_HS | 32'h1 << CTRL_RUN);
    bus(1'b0, REG_CTRL, 32'h0000_0000);
    chk("ctrl_readback", w | 32'h1 << CTRL_HS | 32'h1 << CTRL_RUN, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reference unpacker fed from the wire, compared at every device result
  always @(posedge i_clk) begin
    logic rise, fall, cap;
    logic [11:0] d1, d2;
    logic [7:0] b, m;
    if (pv === 1'b1) begin
      if (pq.size() == 0) chk("pix_extra", 0, 1);
      else chk("pixel", 32'(pq.pop_front()), {ycc, ca, cb, cc});
    end
    if (eav === 1'b1 || sav === 1'b1) begin
      if (eq.size() == 0) chk("code_extra", 0, 1);
      else chk("sync_status", 32'(eq.pop_front()), {eav, sav, fld, vbl});
    end
    rise = link.port_one_pixel_clock & ~pc_q;
    fall = ~link.port_one_pixel_clock & pc_q;
    d1 = link.port_one_data;
    d2 = link.port_two_data;
    b = d1[7:0];
    m = {d1[3:0], d2[11:8]};
    if (link.port_one_hsync & ~hs_q) hs_f = 1'b1;
    pc_q = link.port_one_pixel_clock;
    hs_q = link.port_one_hsync;
    if (fmt1 == FMT_YCC_MUX) cap = les == LES_BOTH ? rise | fall : les == LES_RISE ? rise : fall;
    else cap = les == LES_RISE ? rise : fall;
    if (cap && fmt1 == FMT_YCC_MUX) begin
      if (hs_f) ph = 0;
      hs_f = 1'b0;
      if (cn == 0 && b == TRC_ONES) cn = 1;
      else if (cn == 1 || cn == 2) cn++;
      else if (cn == 3) begin
        eq.push_back({b[4], ~b[4], b[6], b[5]});
        cn = 0;
        ph = 0;
      end else begin
        case (ph)
          0: cbm = b;
          1: y0m = b;
          2: begin crm = b; pq.push_back({1'b1, y0m, cbm, crm}); end
          default: pq.push_back({1'b1, b, cbm, crm});
        endcase
        ph = (ph + 1) % 4;
      end
    end else if (cap && fmt1 >= FMT_RGB_TV && fmt1 <= FMT_RGB_NG) begin
      if (!link.port_one_data_valid) pair = 1'b0;
      else if ((fmt1 == FMT_YCC16 || fmt1 == FMT_RGB_OE) && !pair) begin
        w0 = {d1, d2};
        pair = 1'b1;
      end else if (fmt1 == FMT_YCC16) begin
        pq.push_back({1'b1, w0[23:16], w0[15:8], m});
        pq.push_back({1'b1, d1[11:4], w0[15:8], m});
        pair = 1'b0;
      end else if (fmt1 == FMT_RGB_OE) begin
        pq.push_back({1'b0, d1[11:4], d1[3:0], w0[23:20], w0[19:12]});
        pq.push_back({1'b0, d2[11:4], d2[3:0], w0[11:8], w0[7:0]});
        pair = 1'b0;
      end else if (fmt1 == FMT_YCC24) pq.push_back({1'b1, d1[11:4], d2[7:0], m});
      else pq.push_back({1'b0, d1[11:4], m, d2[7:0]});
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // main sequence: registers, multiplexed codes, every 24-bit map, mismatch
  initial begin
    i_rst_n = 1'b0; rd = 1'b0; wr = 1'b0; adr = 4'h0; wdat = 32'h0000_0000;
    fmt1 = 4'h0; fmt2 = 4'h0; les = 2'h0;
    void'($urandom(32'h181e));
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0000_0000); chk("ctrl_reset", 32'h0000_0000, q);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0000_0000); chk("unmapped", 32'h0000_0000, q);
    for (int e = 0; e < 3; e++) begin
      start(FMT_YCC_MUX, FMT_YCC_MUX, 2'(e), 1'b0);
      for (int s = 0; s < 8; s++) begin
        bus(1'b1, REG_SYNC, $urandom & 32'h0000_008f | 32'(s) << 4);
        repeat (4) bus(1'b1, REG_DATA, 32'($urandom % 254 + 1));
      end
    end
    for (int f = 5; f < 10; f++) begin
      for (int e = 0; e < 4; e++) begin
        start(4'(f), 4'(f), 2'(e), 1'b1);
        repeat (12) bus(1'b1, REG_DATA, $urandom & 32'h00ff_ffff);
      end
    end
    start(FMT_RGB_TV, FMT_YCC16, 2'h0, 1'b0);
    chk("format_mismatch", 32'h0000_0001, 32'(mism));
    start(4'h2, 4'h2, 2'h0, 1'b1);
    repeat (6) bus(1'b1, REG_DATA, $urandom & 32'h00ff_ffff);
    start(FMT_RGB_TV, FMT_RGB_TV, 2'h0, 1'b0);
    chk("format_match", 32'h0000_0000, 32'(mism));
    end_sim();
  end
endmodule
